// *** sim/host_bus_model.sv ***
// Purpose: Host software side of the register port.
// Assumes: Called just after a rising edge of sys_clk.
// Notes:   Strobes are dropped by idle or by a call of the other task, never both in a step.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
  import tdm_irq_pkg::*;
(
  input wire logic sys_clk,
  output var bus_req_t bus
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial bus = '0;
  // One-cycle write; callers keep reserved bits zero
  task automatic write(input logic [8:0] a, input logic [31:0] d);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
  endtask
  // One-cycle read; data is picked up by the bench watcher
  task automatic read(input logic [8:0] a);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge sys_clk);
  endtask
  // Bus released for n cycles
  task automatic idle(input int n);
    bus <= '0;
    repeat (n) @(posedge sys_clk);
  endtask
endmodule // host_bus_model
`default_nettype wire

// *** sim/irq_ctrl_monitor.sv ***
// Purpose: Port-level checks of the event interrupt controller.
// Assumes: Bound to the controller top; one clock domain.
// Notes:   Status words are seen only through register reads.
`timescale 1ns/1ps
`default_nettype none
`include "tdm_irq_regs.svh"
module irq_ctrl_monitor
  import tdm_irq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire bus_req_t bus,
  input wire logic [31:0] reg_rdata,
  input wire logic mac_event_summary,
  input wire logic cpu_queue_event,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking mon_clk @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic mask_touched;
  // Remembers whether software has written the master mask yet
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_touched <= 1'b0;
    end else if (clk_en && bus.wr && bus.addr == `OFS_INTMASK) begin
      mask_touched <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_IRQ_QUIET: assert property (!mask_touched |-> !irq)
    else $error("irq high while all summary sources masked");
  AST_MAC_PEND: assert property ((clk_en && mac_event_summary)[*4]
    ##0 (bus.rd && bus.addr == `OFS_PEND) |=> reg_rdata[27])
    else $error("MAC summary bit not pending");
  AST_CPU_PEND: assert property ((clk_en && cpu_queue_event)[*4]
    ##0 (bus.rd && bus.addr == `OFS_PEND) |=> reg_rdata[26])
    else $error("CPU queue summary bit not pending");
  AST_PEND_RSVD: assert property (clk_en && bus.rd &&
    (bus.addr == `OFS_PEND || bus.addr == `OFS_INTMASK)
    |=> reg_rdata[31:28] == 4'h0)
    else $error("master word reserved bits not zero");
  AST_RTS_RSVD: assert property (clk_en && bus.rd &&
    (bus.addr == `OFS_RTS_CHG || bus.addr == `OFS_RTS_MASK)
    |=> reg_rdata[31:8] == 24'h000000)
    else $error("request to send word reserved bits not zero");
  AST_RTS_MASK_RW: assert property (clk_en && bus.wr &&
    bus.addr == `OFS_RTS_MASK ##1 clk_en && bus.rd &&
    bus.addr == `OFS_RTS_MASK |=> reg_rdata[7:0] == $past(bus.wdata[7:0], 2))
    else $error("request to send mask readback wrong");
  AST_CWLO_MASK_RW: assert property (clk_en && bus.wr &&
    bus.addr == `OFS_CW_LO_MASK ##1 clk_en && bus.rd &&
    bus.addr == `OFS_CW_LO_MASK |=> reg_rdata == $past(bus.wdata, 2))
    else $error("low bundle mask readback wrong");
  AST_INTMASK_RW: assert property (clk_en && bus.wr &&
    bus.addr == `OFS_INTMASK ##1 clk_en && bus.rd &&
    bus.addr == `OFS_INTMASK
    |=> reg_rdata[27:0] == $past(bus.wdata[27:0], 2))
    else $error("master mask readback wrong");
endmodule // irq_ctrl_monitor

bind tdm_packet_event_interrupt_ctrl irq_ctrl_monitor i_monitor (
  .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .bus(bus),
  .reg_rdata(reg_rdata), .mac_event_summary(mac_event_summary),
  .cpu_queue_event(cpu_queue_event), .irq(irq));
`default_nettype wire

// *** sim/testbench.sv ***
// Purpose: Self-checking bench of the event interrupt controller.
// Assumes: Host model issues all register cycles.
// Notes:   Read results are matched against a queue of notes.
`timescale 1ns/1ps
`default_nettype none
`include "tdm_irq_regs.svh"
module testbench;
  import tdm_irq_pkg::*;
  typedef struct {logic [8:0] a; logic [31:0] e; logic [31:0] m;} note_t;
  // ----------------------------------------------------------------
  // Signals and harness
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  bus_req_t bus;
  logic [31:0] reg_rdata;
  port_events_t [7:0] port_events = '0;
  cw_field_chg_t [63:0] cw_events = '0;
  logic mac = 1'b0;
  logic cpuq = 1'b0;
  logic [7:0] rts_pins = 8'h00;
  logic [7:0][1:0] if_type = 16'h0000;
  logic irq;
  note_t expq[$];
  note_t note;
  logic rd_d = 1'b0;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  integer seed = 32'h7625;
  int p, t, k;
  logic [8:0] sa;
  tdm_packet_event_interrupt_ctrl i_dut (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .bus(bus),
    .reg_rdata(reg_rdata), .port_events(port_events),
    .control_word_change_events(cw_events), .mac_event_summary(mac),
    .cpu_queue_event(cpuq), .port_request_to_send_input(rts_pins),
    .port_interface_type(if_type), .irq(irq));
  host_bus_model i_host (.sys_clk(sys_clk), .bus(bus));
  always #5 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic check(input string w, input logic [31:0] e,
                       input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    expq.push_back('{a, e, m});
    i_host.read(a);
  endtask
  task automatic chk_irq(input logic e);
    @(negedge sys_clk);
    check("irq", {31'h0, e}, {31'h0, irq});
    @(posedge sys_clk);
  endtask
  task automatic end_test(input string name);
    i_host.idle(3);
    $display("test %s done", name);
  endtask
  task automatic pulse_event(input int kk, input int pp, input int tt);
    port_events_t [7:0] v;
    v = '0;
    if (kk == 0) v[pp].rx_cas[tt] = 1'b1;
    else if (kk == 1) v[pp].jb_underrun[tt] = 1'b1;
    else v[pp].tx_cas[tt] = 1'b1;
    port_events <= v;
    @(posedge sys_clk);
    port_events <= '0;
  endtask
  // Read data stand in the cycle after the strobe
  always @(posedge sys_clk) rd_d <= bus.rd;
  always @(negedge sys_clk) begin
    if (rd_d) begin
      note = expq.pop_front();
      check($sformatf("read %h", note.a), note.e & note.m, reg_rdata & note.m);
    end
  end
  // Cuts a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    i_host.idle(4);
    rd(`OFS_PEND, 32'h0200_0000, '1);
    rd(`OFS_INTMASK, 32'h0fff_ffff, '1);
    for (p = 0; p < 8; p++) begin
      rd(9'(9'h040 + 4 * p), 32'h0, '1);
      rd(9'(`OFS_JB_BASE + 8 * p), 32'h0, '1);
      rd(9'(`OFS_JB_MASK_BASE + 8 * p), '1, '1);
      rd(9'(`OFS_TX_BASE + 8 * p), 32'h0, '1);
      rd(9'(`OFS_TX_MASK_BASE + 8 * p), '1, '1);
    end
    rd(`OFS_RTS_CHG, 32'h0, '1);
    rd(`OFS_RTS_MASK, 32'h0000_00ff, '1);
    rd(`OFS_CW_LO, '1, '1);
    rd(`OFS_CW_LO_MASK, '1, '1);
    rd(`OFS_CW_HI, '1, '1);
    rd(9'h1fc, 32'h0, '1);
    i_host.write(`OFS_CW_LO, '1);
    i_host.write(`OFS_CW_HI, '1);
    i_host.write(`OFS_PEND, 32'h0200_0000);
    i_host.idle(2);
    rd(`OFS_PEND, 32'h0, '1);
    end_test("reset values");
    for (k = 0; k < 3; k++) begin
      p = $unsigned($random(seed)) % 8;
      t = $unsigned($random(seed)) % 32;
      sa = (k == 0) ? 9'(9'h040 + 4 * p) : 9'(9'h040 * (k + 1) + 8 * p);
      pulse_event(k, p, t);
      i_host.idle(2);
      rd(sa, 32'h1 << t, '1);
      if (k > 0) begin
        rd(`OFS_PEND, 32'h0, '1);
        i_host.write(sa + 9'h4, ~(32'h1 << t));
      end
      i_host.idle(2);
      rd(`OFS_PEND, 32'h1 << (8 * k + p), '1);
      i_host.write(`OFS_INTMASK, 32'h0fff_ffff & ~(32'h1 << (8 * k + p)));
      i_host.idle(3);
      chk_irq(1'b1);
      i_host.write(sa, 32'h0);
      rd(sa, 32'h1 << t, '1);
      i_host.write(sa, 32'h1 << t);
      i_host.write(`OFS_PEND, 32'h1 << (8 * k + p));
      i_host.idle(3);
      chk_irq(1'b0);
      rd(`OFS_PEND, 32'h0, '1);
      i_host.write(`OFS_INTMASK, 32'h0fff_ffff);
      if (k > 0) i_host.write(sa + 9'h4, '1);
      end_test("event path");
    end
    for (k = 0; k < 2; k++) begin
      {mac, cpuq} <= (k == 0) ? 2'b10 : 2'b01;
      i_host.write(`OFS_INTMASK, 32'h0fff_ffff & ~(32'h1 << (27 - k)));
      rd(`OFS_INTMASK, 32'h0fff_ffff & ~(32'h1 << (27 - k)), '1);
      i_host.idle(3);
      chk_irq(1'b1);
      rd(`OFS_PEND, 32'h1 << (27 - k), '1);
      {mac, cpuq} <= 2'b00;
      i_host.idle(3);
      i_host.write(`OFS_PEND, 32'h1 << (27 - k));
      i_host.idle(3);
      chk_irq(1'b0);
      i_host.write(`OFS_INTMASK, 32'h0fff_ffff);
      end_test("summary inputs");
    end
    if_type <= (16'($random(seed)) & 16'hfffc) | 16'h0004;
    rts_pins <= 8'h03;
    i_host.idle(7);
    rd(`OFS_RTS_CHG, 32'h1, '1);
    rd(`OFS_PEND, 32'h0, '1);
    i_host.write(`OFS_RTS_MASK, 32'h0000_00fe);
    i_host.idle(2);
    rd(`OFS_PEND, 32'h0100_0000, '1);
    i_host.write(`OFS_RTS_CHG, 32'h1);
    i_host.write(`OFS_PEND, 32'h0100_0000);
    i_host.write(`OFS_RTS_MASK, 32'h0000_00ff);
    rd(`OFS_RTS_MASK, 32'h0000_00ff, '1);
    end_test("request to send");
    i_host.write(`OFS_CW_LO_MASK, 32'hffff_ffdf);
    rd(`OFS_CW_LO_MASK, 32'hffff_ffdf, '1);
    i_host.write(`OFS_CW_FSEL, 32'h0000_0020);
    cw_events[5] <= 6'h20;
    i_host.idle(1);
    cw_events <= '0;
    i_host.idle(3);
    rd(`OFS_PEND, 32'h0, 32'h0200_0000);
    cw_events[5] <= 6'h01;
    cw_events[40] <= 6'h10;
    i_host.idle(1);
    cw_events <= '0;
    i_host.idle(3);
    rd(`OFS_CW_LO, 32'h0000_0020, '1);
    rd(`OFS_CW_HI, 32'h0000_0100, '1);
    rd(`OFS_PEND, 32'h0200_0000, '1);
    end_test("control word");
    clk_en <= 1'b0;
    pulse_event(0, 3, 7);
    clk_en <= 1'b1;
    i_host.idle(2);
    rd(9'(`OFS_RX_BASE + 12), 32'h0, '1);
    end_test("clock enable");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire

// *** verilog/level_change_detect.sv ***
// Purpose: Synchronise pin levels and pulse on each qualified change.
// Assumes: Pins are asynchronous to sys_clk.
// Notes:   Changes are ignored until the chain has filled after reset.
`timescale 1ns/1ps
`default_nettype none
`include "tdm_irq_regs.svh"
module level_change_detect #(
  parameter int N = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [N-1:0] pin_in,
  input wire logic [N-1:0] qualify,
  output logic [N-1:0] changed
);

  logic [N-1:0] sync_a;
  logic [N-1:0] sync_b;
  logic [N-1:0] last;
  logic [1:0] warm;

  // Two-stage synchroniser, then previous level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
      last <= '0;
      warm <= 2'h0;
    end else if (clk_en) begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      last <= sync_b;
      if (warm != `SYNC_WARMUP) begin
        warm <= warm + 2'h1;
      end
    end
  end

  // Edge of either polarity, only once warmed up
  assign changed = (warm == `SYNC_WARMUP) ? ((sync_b ^ last) & qualify)
                                          : '0;

endmodule // level_change_detect
`default_nettype wire

// *** verilog/tdm_irq_pkg.sv ***
// Purpose: Types shared by the interrupt controller files.
// Assumes: Eight ports, 64 bundles.
// Notes:   Offsets and resets live in tdm_irq_regs.svh.
package tdm_irq_pkg;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  // Per-port timeslot event pulses
  typedef struct packed {
    logic [31:0] tx_cas;
    logic [31:0] jb_underrun;
    logic [31:0] rx_cas;
  } port_events_t;

  // Per-bundle field change: [5] loss, [4] remote, [3:2] modifier,
  // [1:0] fragmentation
  typedef logic [5:0] cw_field_chg_t;

endpackage : tdm_irq_pkg

// *** verilog/tdm_irq_regs.svh ***
// Purpose: Register offsets, reset values and bit positions of the
//          packet event interrupt controller.
// Assumes: Byte addresses on a 9-bit register port.
// Notes:   Definitions only.
`ifndef TDM_IRQ_REGS_SVH
`define TDM_IRQ_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define OFS_PEND 9'h000
`define OFS_INTMASK 9'h004
`define OFS_RX_BASE 9'h040
`define OFS_JB_BASE 9'h080
`define OFS_JB_MASK_BASE 9'h084
`define OFS_TX_BASE 9'h0c0
`define OFS_TX_MASK_BASE 9'h0c4
`define OFS_RTS_CHG 9'h100
`define OFS_RTS_MASK 9'h104
`define OFS_CW_LO 9'h140
`define OFS_CW_LO_MASK 9'h144
`define OFS_CW_HI 9'h148
`define OFS_CW_FSEL 9'h180

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PEND 28'h0000000
`define RST_INTMASK 28'hfffffff
`define RST_STATUS 32'h00000000
`define RST_MASK32 32'hffffffff
`define RST_CW_CHG 32'hffffffff
`define RST_RTS_CHG 8'h00
`define RST_RTS_MASK 8'hff
`define RST_FSEL 6'h00

// ----------------------------------------------------------------
// Summary bit positions and codes
// ----------------------------------------------------------------
`define BIT_MAC 27
`define BIT_CPUQ 26
`define BIT_CW 25
`define BIT_RTS 24
`define LSB_TX 16
`define LSB_JB 8
`define LSB_RX 0
`define IF_TYPE_ASYNC 2'h0
`define SYNC_WARMUP 2'h3

`endif

// *** verilog/tdm_packet_event_interrupt_ctrl.sv ***
// Purpose: Two-level interrupt aggregator for eight TDM ports and
//          64 bundles, with a master pending word and one irq line.
// Assumes: Event inputs are one-cycle pulses on sys_clk; request to
//          send pins are asynchronous; MAC and CPU queue summaries
//          are levels on sys_clk.
// Notes:   Read data stand only in the cycle after the read strobe.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "tdm_irq_regs.svh"

module tdm_packet_event_interrupt_ctrl
  import tdm_irq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire bus_req_t bus,
  output logic [31:0] reg_rdata,
  input wire port_events_t [7:0] port_events,
  input wire cw_field_chg_t [63:0] control_word_change_events,
  input wire logic mac_event_summary,
  input wire logic cpu_queue_event,
  input wire logic [7:0] port_request_to_send_input,
  input wire logic [7:0][1:0] port_interface_type,
  output logic irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Byte offset of a port's word: four or eight bytes apart
  function automatic logic [8:0] port_ofs(input logic [8:0] base,
                                          input logic [2:0] p,
                                          input logic wide);
    logic [8:0] step;
    step = wide ? {3'h0, p, 3'h0} : {4'h0, p, 2'h0};
    return base + step;
  endfunction

  // Any status bit that its mask lets through
  function automatic logic any_unmasked(input logic [31:0] flags,
                                        input logic [31:0] mask);
    return |(flags & ~mask);
  endfunction

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------

  // Address hits of the single registers
  wire hit_pend = bus.addr == `OFS_PEND;
  wire hit_intmask = bus.addr == `OFS_INTMASK;
  wire hit_rts_chg = bus.addr == `OFS_RTS_CHG;
  wire hit_rts_mask = bus.addr == `OFS_RTS_MASK;
  wire hit_cw_lo = bus.addr == `OFS_CW_LO;
  wire hit_cw_lo_mask = bus.addr == `OFS_CW_LO_MASK;
  wire hit_cw_hi = bus.addr == `OFS_CW_HI;
  wire hit_fsel = bus.addr == `OFS_CW_FSEL;

  // Write strobes for the single registers
  wire wr_pend = bus.wr && hit_pend;
  wire wr_intmask = bus.wr && hit_intmask;
  wire wr_rts_chg = bus.wr && hit_rts_chg;
  wire wr_rts_mask = bus.wr && hit_rts_mask;
  wire wr_cw_lo = bus.wr && hit_cw_lo;
  wire wr_cw_lo_mask = bus.wr && hit_cw_lo_mask;
  wire wr_cw_hi = bus.wr && hit_cw_hi;
  wire wr_fsel = bus.wr && hit_fsel;

  // ----------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------

  logic [27:0] intmask;
  logic [7:0] rts_mask;
  logic [31:0] cw_lo_mask;
  logic [5:0] cw_fsel;

  // Plain read/write masks; upper reserved bits are dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      intmask <= `RST_INTMASK;
      rts_mask <= `RST_RTS_MASK;
      cw_lo_mask <= `RST_MASK32;
      cw_fsel <= `RST_FSEL;
    end else if (clk_en) begin
      if (wr_intmask) begin
        intmask <= bus.wdata[27:0];
      end
      if (wr_rts_mask) begin
        rts_mask <= bus.wdata[7:0];
      end
      if (wr_cw_lo_mask) begin
        cw_lo_mask <= bus.wdata;
      end
      if (wr_fsel) begin
        cw_fsel <= bus.wdata[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-port timeslot registers
  // ----------------------------------------------------------------

  logic [7:0][31:0] rx_flags;
  logic [7:0][31:0] jb_flags;
  logic [7:0][31:0] jb_mask;
  logic [7:0][31:0] tx_flags;
  logic [7:0][31:0] tx_mask;
  logic [7:0] rx_any;
  logic [7:0] jb_any;
  logic [7:0] tx_any;
  logic [8:0][31:0] rd_acc;

  assign rd_acc[0] = 32'h00000000;

  for (genvar p = 0; p < 8; p++) begin : g_port
    wire hit_rx = bus.addr == port_ofs(`OFS_RX_BASE, 3'(p), 1'b0);
    wire hit_jb = bus.addr == port_ofs(`OFS_JB_BASE, 3'(p), 1'b1);
    wire hit_jbm = bus.addr == port_ofs(`OFS_JB_MASK_BASE, 3'(p), 1'b1);
    wire hit_tx = bus.addr == port_ofs(`OFS_TX_BASE, 3'(p), 1'b1);
    wire hit_txm = bus.addr == port_ofs(`OFS_TX_MASK_BASE, 3'(p), 1'b1);

    // Receive CAS change, one bit per timeslot
    w1c_word #(.W(32), .INIT(`RST_STATUS)) u_rx (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .set_bits(port_events[p].rx_cas),
      .clr_bits((bus.wr && hit_rx) ? bus.wdata : 32'h00000000),
      .flags(rx_flags[p])
    );

    // Jitter buffer underrun, one bit per timeslot
    w1c_word #(.W(32), .INIT(`RST_STATUS)) u_jb (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .set_bits(port_events[p].jb_underrun),
      .clr_bits((bus.wr && hit_jb) ? bus.wdata : 32'h00000000),
      .flags(jb_flags[p])
    );

    // Transmit CAS change, one bit per timeslot
    w1c_word #(.W(32), .INIT(`RST_STATUS)) u_tx (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .set_bits(port_events[p].tx_cas),
      .clr_bits((bus.wr && hit_tx) ? bus.wdata : 32'h00000000),
      .flags(tx_flags[p])
    );

    // Per-port masks
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        jb_mask[p] <= `RST_MASK32;
        tx_mask[p] <= `RST_MASK32;
      end else if (clk_en) begin
        if (bus.wr && hit_jbm) begin
          jb_mask[p] <= bus.wdata;
        end
        if (bus.wr && hit_txm) begin
          tx_mask[p] <= bus.wdata;
        end
      end
    end

    // Unmasked summaries of this port
    assign rx_any[p] = |rx_flags[p];
    assign jb_any[p] = any_unmasked(jb_flags[p], jb_mask[p]);
    assign tx_any[p] = any_unmasked(tx_flags[p], tx_mask[p]);

    // Read terms of this port, ORed along the chain
    assign rd_acc[p+1] = rd_acc[p]
      | (hit_rx ? rx_flags[p] : 32'h00000000)
      | (hit_jb ? jb_flags[p] : 32'h00000000)
      | (hit_jbm ? jb_mask[p] : 32'h00000000)
      | (hit_tx ? tx_flags[p] : 32'h00000000)
      | (hit_txm ? tx_mask[p] : 32'h00000000);
  end

  // ----------------------------------------------------------------
  // Request to send changes
  // ----------------------------------------------------------------

  logic [7:0] rts_async;
  logic [7:0] rts_event;
  logic [7:0] rts_flags;

  // Only ports in asynchronous serial mode report changes
  for (genvar p = 0; p < 8; p++) begin : g_rts_mode
    assign rts_async[p] = port_interface_type[p] == `IF_TYPE_ASYNC;
  end

  // Pins pass two flops first; changes seen while the chain fills
  // after reset are dropped, so no false edge follows reset
  level_change_detect #(.N(8)) u_rts_detect (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_in(port_request_to_send_input),
    .qualify(rts_async),
    .changed(rts_event)
  );

  w1c_word #(.W(8), .INIT(`RST_RTS_CHG)) u_rts (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .set_bits(rts_event),
    .clr_bits(wr_rts_chg ? bus.wdata[7:0] : 8'h00),
    .flags(rts_flags)
  );

  // ----------------------------------------------------------------
  // Control word field changes per bundle
  // ----------------------------------------------------------------

  logic [63:0] cw_event;
  logic [31:0] cw_lo_flags;
  logic [31:0] cw_hi_flags;

  // A bundle reports only fields that the select mask lets through
  for (genvar b = 0; b < 64; b++) begin : g_bundle
    assign cw_event[b] = |(control_word_change_events[b] & ~cw_fsel);
  end

  w1c_word #(.W(32), .INIT(`RST_CW_CHG)) u_cw_lo (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .set_bits(cw_event[31:0]),
    .clr_bits(wr_cw_lo ? bus.wdata : 32'h00000000),
    .flags(cw_lo_flags)
  );

  w1c_word #(.W(32), .INIT(`RST_CW_CHG)) u_cw_hi (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .set_bits(cw_event[63:32]),
    .clr_bits(wr_cw_hi ? bus.wdata : 32'h00000000),
    .flags(cw_hi_flags)
  );

  // ----------------------------------------------------------------
  // Master pending word
  // ----------------------------------------------------------------

  logic [27:0] pend_set;
  logic [27:0] pend;

  // Summary sources. High bundles carry no mask in this block, so any
  // high bundle change raises bit 25; the low word goes through its
  // mask. Receive CAS words have no mask of their own.
  assign pend_set[`BIT_MAC] = mac_event_summary;
  assign pend_set[`BIT_CPUQ] = cpu_queue_event;
  assign pend_set[`BIT_CW] = any_unmasked(cw_lo_flags, cw_lo_mask)
                             | (|cw_hi_flags);
  assign pend_set[`BIT_RTS] = any_unmasked({24'h000000, rts_flags},
                                           {24'hffffff, rts_mask});
  assign pend_set[`LSB_TX +: 8] = tx_any;
  assign pend_set[`LSB_JB +: 8] = jb_any;
  assign pend_set[`LSB_RX +: 8] = rx_any;

  // Sets again while a lower unmasked bit stays set, so software
  // clears the lower word before the pending bit
  w1c_word #(.W(28), .INIT(`RST_PEND)) u_pend (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .set_bits(pend_set),
    .clr_bits(wr_pend ? bus.wdata[27:0] : 28'h0000000),
    .flags(pend)
  );

  // ----------------------------------------------------------------
  // Read data and interrupt line
  // ----------------------------------------------------------------

  logic [31:0] rd_single;

  // Single registers; reserved bits read zero
  assign rd_single =
      ((bus.addr == `OFS_PEND) ? {4'h0, pend} : 32'h00000000)
    | ((bus.addr == `OFS_INTMASK) ? {4'h0, intmask} : 32'h00000000)
    | ((bus.addr == `OFS_RTS_CHG) ? {24'h000000, rts_flags}
                                  : 32'h00000000)
    | ((bus.addr == `OFS_RTS_MASK) ? {24'h000000, rts_mask}
                                   : 32'h00000000)
    | ((bus.addr == `OFS_CW_LO) ? cw_lo_flags : 32'h00000000)
    | ((bus.addr == `OFS_CW_LO_MASK) ? cw_lo_mask : 32'h00000000)
    | ((bus.addr == `OFS_CW_HI) ? cw_hi_flags : 32'h00000000)
    | ((bus.addr == `OFS_CW_FSEL) ? {26'h0000000, cw_fsel}
                                  : 32'h00000000);

  // Data stand one cycle after the read, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (clk_en) begin
      reg_rdata <= bus.rd ? (rd_single | rd_acc[8]) : 32'h00000000;
    end
  end

  // Interrupt follows unmasked pending bits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(pend & ~intmask);
    end
  end

endmodule // tdm_packet_event_interrupt_ctrl
`default_nettype wire

// *** verilog/w1c_word.sv ***
// Purpose: One latched event word, write-one-to-clear.
// Assumes: Set and clear come from logic on sys_clk.
// Notes:   A set in the clearing cycle wins.
`timescale 1ns/1ps
`default_nettype none
module w1c_word #(
  parameter int W = 32,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [W-1:0] set_bits,
  input wire logic [W-1:0] clr_bits,
  output logic [W-1:0] flags
);

  // Latch events; clear only bits with no new event
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags <= INIT;
    end else if (clk_en) begin
      flags <= set_bits | (flags & ~clr_bits);
    end
  end

endmodule // w1c_word
`default_nettype wire
